/* design/rvs_regs.v */
/*
  voltage-setting register bank for two linear regulators (set A) and one
  core buck converter (set B), reached over apb, with code-to-millivolt
  decoders for the regulator controls.
  assumes an apb master on pclk; set selection comes from a software register.
*/
// Function
// - linear regulator a-set bit 7: 0 normal, 1 sleep, when set A selected
// - linear code in bits 5:0; codes 0 to 2 give 0.90 V
// - code 3 gives 0.95 V, each step adds 50 mV
// - code 100010 gives 2.50 V, same 50 mV progression continues
// - code 111000 and above saturate at 3.60 V
// - core buck b-set bit 7: 0 synchronous, 1 sleep, when set B selected
// - buck code bits 6:0, 0.30 V plus 10 mV per step to 1.56 V
// - buck code range applies to the pwm operating mode
`timescale 1ns/10ps
`include "rvs_map.vh"

module rvs_regs (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  output reg lin_reg_ten_sleep_sel_a,
  output reg [11:0] lin_reg_ten_target_mv,
  output reg lin_reg_ten_apply,
  output reg lin_reg_eleven_sleep_sel_a,
  output reg [11:0] lin_reg_eleven_target_mv,
  output reg lin_reg_eleven_apply,
  output reg core_buck_two_sleep_sel_b,
  output reg [11:0] core_buck_two_target_mv,
  output reg core_buck_two_pwm_apply
);

  reg [7:0] ldo_ten_set_a_voltage_reg;
  reg [7:0] ldo_eleven_set_a_voltage_reg;
  reg [7:0] core_buck_two_set_b_voltage_reg;
  // bit 0: set A in use for the linear regulators, bit 1: set B for the buck
  // reset leaves both sets deselected, so no target is driven until chosen
  reg [1:0] set_select_reg;

  wire wr_en;
  wire rd_en;
  wire hit;
  wire [5:0] lin_reg_ten_voltage_code_a;
  wire [5:0] lin_reg_eleven_voltage_code_a;
  wire [6:0] core_buck_two_voltage_code_b;
  // per-register write strobes
  wire wr_ldo_ten;
  wire wr_ldo_eleven;
  wire wr_core_buck;
  wire wr_set_select;
  wire set_a_in_use;
  wire set_b_in_use;

  // linear regulator code to millivolts
  function [11:0] lin_mv;
    input [5:0] code;
    reg [11:0] steps;
    begin
      steps = {6'h00, code} - {6'h00, `RVS_LIN_FLOOR_CODE};
      if (code < `RVS_LIN_FLOOR_CODE) begin
        lin_mv = `RVS_LIN_FLOOR_MV;
      // without saturation the top code gives 3950, still inside twelve bits
      end else if (code >= `RVS_LIN_SAT_CODE) begin
        lin_mv = `RVS_LIN_MAX_MV;
      end else begin
        lin_mv = `RVS_LIN_BASE_MV + steps * `RVS_LIN_STEP_MV;
      end
    end
  endfunction

  // core buck code to millivolts, held at the top value
  function [11:0] buck_mv;
    input [6:0] code;
    reg [11:0] raw;
    begin
      raw = `RVS_BUCK_BASE_MV + {5'h00, code} * `RVS_BUCK_STEP_MV;
      if (raw > `RVS_BUCK_MAX_MV) begin
        buck_mv = `RVS_BUCK_MAX_MV;
      end else begin
        buck_mv = raw;
      end
    end
  endfunction

  // decoded for both the error answer and the write gate
  function hit_addr;
    input [11:0] a;
    begin
      case (a)
        `RVS_OFS_LDO_TEN_A: hit_addr = 1'b1;
        `RVS_OFS_LDO_ELEVEN_A: hit_addr = 1'b1;
        `RVS_OFS_CORE_BUCK_B: hit_addr = 1'b1;
        `RVS_OFS_SET_SELECT: hit_addr = 1'b1;
        default: hit_addr = 1'b0;
      endcase
    end
  endfunction

  // zero-wait slave; unmapped addresses answer with pslverr and zero data
  assign pready = 1'b1;
  assign hit = hit_addr(paddr);
  assign pslverr = psel & penable & ~hit;
  assign wr_en = psel & penable & pwrite & pstrb[0] & hit;
  assign rd_en = psel & ~penable & ~pwrite;
  // strobes for the single-register write processes
  assign wr_ldo_ten = wr_en & (paddr == `RVS_OFS_LDO_TEN_A);
  assign wr_ldo_eleven = wr_en & (paddr == `RVS_OFS_LDO_ELEVEN_A);
  assign wr_core_buck = wr_en & (paddr == `RVS_OFS_CORE_BUCK_B);
  assign wr_set_select = wr_en & (paddr == `RVS_OFS_SET_SELECT);
  assign set_a_in_use = set_select_reg[0];
  assign set_b_in_use = set_select_reg[1];

  assign lin_reg_ten_voltage_code_a = ldo_ten_set_a_voltage_reg[`RVS_LIN_CODE_MSB:0];
  assign lin_reg_eleven_voltage_code_a = ldo_eleven_set_a_voltage_reg[`RVS_LIN_CODE_MSB:0];
  assign core_buck_two_voltage_code_b = core_buck_two_set_b_voltage_reg[`RVS_BUCK_CODE_MSB:0];

  // one process per register keeps each strobe local; all eight bits
  // stored, so the reserved bit reads back as written
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ldo_ten_set_a_voltage_reg <= `RVS_RESET_LDO;
    end else if (wr_ldo_ten) begin
      ldo_ten_set_a_voltage_reg <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ldo_eleven_set_a_voltage_reg <= `RVS_RESET_LDO;
    end else if (wr_ldo_eleven) begin
      ldo_eleven_set_a_voltage_reg <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_buck_two_set_b_voltage_reg <= `RVS_RESET_BUCK;
    end else if (wr_core_buck) begin
      core_buck_two_set_b_voltage_reg <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_select_reg <= `RVS_RESET_SEL;
    end else if (wr_set_select) begin
      set_select_reg <= pwdata[1:0];
    end
  end

  // read data registered in the setup cycle, valid in the access phase;
  // this keeps pready constant at the cost of a flop per data bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        `RVS_OFS_LDO_TEN_A: prdata <= {24'h000000, ldo_ten_set_a_voltage_reg};
        `RVS_OFS_LDO_ELEVEN_A: prdata <= {24'h000000, ldo_eleven_set_a_voltage_reg};
        `RVS_OFS_CORE_BUCK_B: prdata <= {24'h000000, core_buck_two_set_b_voltage_reg};
        `RVS_OFS_SET_SELECT: prdata <= {30'h00000000, set_select_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // outputs zero while the owning set is not selected, so a deselected
  // regulator never sees a stale code
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_reg_ten_sleep_sel_a <= 1'b0;
      lin_reg_ten_target_mv <= 12'd0;
      lin_reg_ten_apply <= 1'b0;
    end else begin
      lin_reg_ten_apply <= set_a_in_use;
      lin_reg_ten_sleep_sel_a <= set_a_in_use & ldo_ten_set_a_voltage_reg[`RVS_SLEEP_BIT];
      lin_reg_ten_target_mv <= set_a_in_use ? lin_mv(lin_reg_ten_voltage_code_a) : 12'd0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_reg_eleven_sleep_sel_a <= 1'b0;
      lin_reg_eleven_target_mv <= 12'd0;
      lin_reg_eleven_apply <= 1'b0;
    end else begin
      lin_reg_eleven_apply <= set_a_in_use;
      lin_reg_eleven_sleep_sel_a <= set_a_in_use & ldo_eleven_set_a_voltage_reg[`RVS_SLEEP_BIT];
      lin_reg_eleven_target_mv <= set_a_in_use ? lin_mv(lin_reg_eleven_voltage_code_a) : 12'd0;
    end
  end

  // the pwm-range target is only meaningful in pwm operation
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_buck_two_sleep_sel_b <= 1'b0;
      core_buck_two_target_mv <= 12'd0;
      core_buck_two_pwm_apply <= 1'b0;
    end else begin
      core_buck_two_pwm_apply <= set_b_in_use;
      core_buck_two_sleep_sel_b <= set_b_in_use & core_buck_two_set_b_voltage_reg[`RVS_SLEEP_BIT];
      core_buck_two_target_mv <= set_b_in_use ? buck_mv(core_buck_two_voltage_code_b) : 12'd0;
    end
  end

endmodule // rvs_regs

/* shared/rvs_map.vh */
/*
  register offsets, field positions, reset values and decode constants
  for the regulator voltage-setting register bank.
  assumes byte-addressed apb with one register per 32-bit word.
*/
`ifndef RVS_MAP_VH
`define RVS_MAP_VH

`define RVS_IDX_LDO_TEN_A 8'hB2
`define RVS_IDX_LDO_ELEVEN_A 8'hB3
`define RVS_IDX_CORE_BUCK_B 8'hB4
`define RVS_IDX_SET_SELECT 8'hBC
// byte address is four times the register index
`define RVS_OFS_LDO_TEN_A {2'b00, `RVS_IDX_LDO_TEN_A, 2'b00}
`define RVS_OFS_LDO_ELEVEN_A {2'b00, `RVS_IDX_LDO_ELEVEN_A, 2'b00}
`define RVS_OFS_CORE_BUCK_B {2'b00, `RVS_IDX_CORE_BUCK_B, 2'b00}
`define RVS_OFS_SET_SELECT {2'b00, `RVS_IDX_SET_SELECT, 2'b00}

`define RVS_SLEEP_BIT 7
`define RVS_RSVD_BIT 6
`define RVS_LIN_CODE_MSB 5
`define RVS_BUCK_CODE_MSB 6

`define RVS_RESET_LDO 8'h00
`define RVS_RESET_BUCK 8'h00
`define RVS_RESET_SEL 2'h0

`define RVS_LIN_FLOOR_CODE 6'h03
`define RVS_LIN_FLOOR_MV 12'd900
`define RVS_LIN_BASE_MV 12'd950
`define RVS_LIN_STEP_MV 12'd50
`define RVS_LIN_SAT_CODE 6'h38
`define RVS_LIN_MAX_MV 12'd3600
`define RVS_BUCK_BASE_MV 12'd300
`define RVS_BUCK_STEP_MV 12'd10
`define RVS_BUCK_MAX_MV 12'h618

`endif

/* tb/rvs_regs_assertions.sv */
/* rvs_regs_chk: port properties of rvs_regs.
   assumes one pclk domain with async active-low presetn. */
`timescale 1ns/10ps
module rvs_regs_chk (
  input wire pclk, presetn, psel, penable, pslverr,
  input wire lin_reg_ten_sleep_sel_a, lin_reg_ten_apply, core_buck_two_sleep_sel_b, core_buck_two_pwm_apply,
  input wire [11:0] lin_reg_ten_target_mv, core_buck_two_target_mv
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_err_gate: assert property (pslverr |-> psel && penable) else $error("stray error");
  a_sleep_a: assert property (lin_reg_ten_sleep_sel_a |-> lin_reg_ten_apply) else $error("a sleep");
  a_sleep_b: assert property (core_buck_two_sleep_sel_b |-> core_buck_two_pwm_apply)
    else $error("b sleep");
  a_lin_off: assert property (lin_reg_ten_apply || !lin_reg_ten_target_mv) else $error("a leak");
  a_buck_off: assert property (core_buck_two_pwm_apply || !core_buck_two_target_mv)
    else $error("b leak");
  a_lin_range: assert property (lin_reg_ten_apply |-> lin_reg_ten_target_mv inside {[900:3600]})
    else $error("a range");
  a_buck_range: assert property (core_buck_two_pwm_apply |-> core_buck_two_target_mv inside {[300:1560]})
    else $error("b range");
  // buck target moves only one edge after a bus write
  a_idle_hold: assert property (!$past(psel, 2) |-> $stable(core_buck_two_target_mv))
    else $error("b moved");
  c_lin_top: cover property (lin_reg_ten_sleep_sel_a && lin_reg_ten_target_mv == 3600);
  c_buck_on: cover property (core_buck_two_target_mv == 1450);
  c_err: cover property (pslverr);
endmodule // rvs_regs_chk
bind rvs_regs rvs_regs_chk chk (.*);

/* tb/tb_top.sv */
/* tb_top: apb master tasks and scenarios for rvs_regs.
   assumes byte address = register index x4. */
`timescale 1ns/10ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [3:0] pstrb = 4'h1;
  logic [11:0] paddr = 0, e;
  logic [31:0] pwdata = 0, rd;
  wire pready, pslverr, lin_reg_ten_sleep_sel_a, lin_reg_ten_apply, lin_reg_eleven_sleep_sel_a, lin_reg_eleven_apply;
  wire core_buck_two_sleep_sel_b, core_buck_two_pwm_apply;
  wire [11:0] lin_reg_ten_target_mv, lin_reg_eleven_target_mv, core_buck_two_target_mv;
  wire [31:0] prdata;
  int mismatches = 0, cmp_count = 0, n;
  rvs_regs dut (.*);
  initial forever #5 pclk = ~pclk;
  task summarize;
    $display("cmp %0d mis %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] x);
    cmp_count++;
    if (g !== x) $display("[FAIL] %0t got %h want %h", $time, g, x);
    mismatches += (g !== x);
  endtask
  task xfer(input w, input [11:0] a, input [7:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a[9:0], 26'h0, d};
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 9);
    chk(n < 9, 1);
    if (n == 9) summarize;
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task s_lin;
    logic [5:0] c [8] = '{0, 2, 3, 8, 34, 55, 56, 63};
    xfer(1, 12'h0BC, 8'h01);
    foreach (c[i]) begin
      e = c[i] < 3 ? 900 : c[i] > 55 ? 3600 : 950 + 50 * (c[i] - 3);
      xfer(1, 12'h0B2, {i[0], 1'b1, c[i]});
      xfer(1, 12'h0B3, {~i[0], 1'b0, c[i]});
      xfer(0, 12'h0B2, 8'h00);
      chk(rd, {i[0], 1'b1, c[i]});
      xfer(0, 12'h0B3, 8'h00);
      chk(rd, {~i[0], 1'b0, c[i]});
      chk({lin_reg_ten_apply, lin_reg_ten_sleep_sel_a, lin_reg_ten_target_mv}, {1'b1, i[0], e});
      chk({lin_reg_eleven_apply, lin_reg_eleven_sleep_sel_a, lin_reg_eleven_target_mv}, {1'b1, ~i[0], e});
    end
  endtask
  task s_buck;
    logic [6:0] c [5] = '{0, 1, 60, 115, 127};
    xfer(1, 12'h0BC, 8'h02);
    foreach (c[i]) begin
      e = c[i] > 125 ? 1560 : 300 + 10 * c[i];
      xfer(1, 12'h0B4, {i[0], c[i]});
      xfer(1, 12'h3FF, 8'h00);
      chk({core_buck_two_sleep_sel_b, core_buck_two_target_mv}, {i[0], e});
      chk({er, core_buck_two_pwm_apply, lin_reg_ten_apply, lin_reg_ten_target_mv}, 15'h6000);
    end
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    chk({lin_reg_ten_apply, lin_reg_eleven_apply, core_buck_two_pwm_apply, lin_reg_ten_target_mv}, 0);
    presetn <= 1;
    s_lin;
    s_buck;
    summarize;
  end
endmodule // tb_top
